//--- csac_regs.vh
// Register offsets, fields, reset values and timing counts of the core status and auxiliary control block
`ifndef CSAC_REGS_VH
`define CSAC_REGS_VH
`define CSAC_ADDR_AUX       8'h8E
`define CSAC_ADDR_PTRBOOT   8'hA2
`define CSAC_ADDR_STATUS    8'hD0
`define CSAC_ADDR_PTR_HIGH  8'h83
`define CSAC_ADDR_PTR_LOW   8'h84
`define CSAC_STATUS_RESET   8'h00
`define CSAC_AUX_RESET      8'h0D
`define CSAC_PTRBOOT_RESET  8'h00
`define CSAC_SW_FULL_CARRY  7
`define CSAC_SW_HALF_CARRY  6
`define CSAC_SW_USER_ZERO   5
`define CSAC_SW_BANK_HI     4
`define CSAC_SW_BANK_LO     3
`define CSAC_SW_RANGE       2
`define CSAC_SW_USER_ONE    1
`define CSAC_SW_PARITY      0
`define CSAC_AX_RESERVED    7
`define CSAC_AX_WIDE        6
`define CSAC_AX_STRETCH     5
`define CSAC_AX_PHSUP       4
`define CSAC_AX_SIZE_HI     3
`define CSAC_AX_SIZE_LO     2
`define CSAC_AX_OFFCHIP     1
`define CSAC_AX_LATCH_GATE  0
`define CSAC_PB_PTR_SEL     0
`define CSAC_PB_WMASK       8'h29
`define CSAC_STROBE_SHORT   4'd3
`define CSAC_STROBE_LONG    4'd15
`define CSAC_LATCH_DIV      2'd3
`define CSAC_SIZE_256       12'h100
`define CSAC_SIZE_512       12'h200
`define CSAC_SIZE_1K        12'h400
`define CSAC_SIZE_2K        12'h800
`endif

//--- csac_bus_timer.v
// External move strobe and address latch pulse timing
`timescale 1ns/1ps
`include "csac_regs.vh"
module csac_bus_timer (
  // Clock and reset
  input  wire       clk_sys,
  input  wire       rst_n,
  // Control
  input  wire       stretch,
  input  wire       latch_gate,
  input  wire       move_start,
  // Timing outputs
  output reg        strobe_q,
  output reg        latch_q,
  output wire       busy
);
  reg  [3:0] strobe_cnt_q;
  reg  [3:0] strobe_cnt_d;
  reg  [1:0] div_cnt_q;
  reg        move_latch_q;

  assign busy = strobe_q | move_latch_q;

  always @*
  begin
    strobe_cnt_d = strobe_cnt_q;
    if (move_start && !busy)
      strobe_cnt_d = stretch ? `CSAC_STROBE_LONG : `CSAC_STROBE_SHORT;
    else if (strobe_cnt_q != 4'h0)
      strobe_cnt_d = strobe_cnt_q - 4'h1;
  end

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strobe_cnt_q <= 4'h0;
      strobe_q     <= 1'b0;
      div_cnt_q    <= 2'h0;
      latch_q      <= 1'b0;
      move_latch_q <= 1'b0;
    end
    else
    begin
      move_latch_q <= move_start && !busy;
      strobe_cnt_q <= strobe_cnt_d;
      strobe_q     <= move_latch_q | (strobe_cnt_q != 4'h0);
      div_cnt_q    <= (div_cnt_q == `CSAC_LATCH_DIV - 2'd1) ? 2'h0 : div_cnt_q + 2'h1;
      if (latch_gate)
        latch_q <= move_start && !busy;
      else
        latch_q <= (div_cnt_q == 2'h0);
    end
  end
endmodule // csac_bus_timer

//--- csac_core_regs.v
// Status word, auxiliary control, pointer select and external move routing
`timescale 1ns/1ps
`include "csac_regs.vh"
module csac_core_regs (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        rst_n,
  // Special-function access
  input  wire [7:0]  sfr_addr,
  input  wire        sfr_wr,
  input  wire [7:0]  sfr_wdata,
  output reg  [7:0]  sfr_rdata,
  // ALU flag updates
  input  wire [7:0]  main_operand_register,
  input  wire        carry_upd,
  input  wire        carry_in,
  input  wire        half_upd,
  input  wire        half_in,
  input  wire        range_upd,
  input  wire        range_in,
  // External move request
  input  wire        move_req,
  input  wire        move_ptr,
  input  wire [7:0]  upper_address_port_sfr,
  // Status outputs
  output wire [1:0]  working_bank_select,
  output wire        wide_transfer_enable,
  output wire        pointer_select,
  output wire [11:0] onchip_memory_bytes,
  // External move outputs
  output reg         move_onchip_q,
  output reg         move_offchip_q,
  output reg  [15:0] move_addr_q,
  output reg  [7:0]  upper_address_port_q,
  output wire        rw_strobe,
  output wire        addr_latch_strobe,
  output wire        move_busy
);
  reg  [7:0]  status_q;
  reg  [7:0]  status_d;
  reg  [7:0]  aux_q;
  reg  [7:0]  ptrboot_q;
  reg  [15:0] ptr0_q;
  reg  [15:0] ptr1_q;
  reg  [11:0] size_bytes;
  reg  [15:0] eff_addr;
  reg         go_onchip;
  wire [15:0] ptr_cur;
  wire        wr_status;
  wire        wr_aux;
  wire        wr_ptrboot;
  wire        wr_ptr_high;
  wire        wr_ptr_low;
  wire        move_accept;
  wire        move_start_offchip;

  // Write decode per register
  assign wr_status          = sfr_wr && (sfr_addr == `CSAC_ADDR_STATUS);
  assign wr_aux             = sfr_wr && (sfr_addr == `CSAC_ADDR_AUX);
  assign wr_ptrboot         = sfr_wr && (sfr_addr == `CSAC_ADDR_PTRBOOT);
  assign wr_ptr_high        = sfr_wr && (sfr_addr == `CSAC_ADDR_PTR_HIGH);
  assign wr_ptr_low         = sfr_wr && (sfr_addr == `CSAC_ADDR_PTR_LOW);
  assign move_accept        = move_req && !move_busy;
  assign move_start_offchip = move_req && !go_onchip;

  assign working_bank_select  = status_q[`CSAC_SW_BANK_HI:`CSAC_SW_BANK_LO];
  assign wide_transfer_enable = aux_q[`CSAC_AX_WIDE];
  assign pointer_select       = ptrboot_q[`CSAC_PB_PTR_SEL];
  assign onchip_memory_bytes  = size_bytes;
  assign ptr_cur  = pointer_select ? ptr1_q : ptr0_q;

  // Move address: pointer or port byte with operand byte
  always @*
  begin
    if (move_ptr)
      eff_addr = ptr_cur;
    else
      eff_addr = {upper_address_port_sfr, main_operand_register};
  end

  // Expanded memory size decode
  always @*
  begin
    case (aux_q[`CSAC_AX_SIZE_HI:`CSAC_AX_SIZE_LO])
      2'b00:   size_bytes = `CSAC_SIZE_256;
      2'b01:   size_bytes = `CSAC_SIZE_512;
      2'b10:   size_bytes = `CSAC_SIZE_1K;
      default: size_bytes = `CSAC_SIZE_2K;
    endcase
  end

  // Expanded memory hit below the selected size
  always @*
  begin
    go_onchip = 1'b0;
    if (!aux_q[`CSAC_AX_OFFCHIP])
      go_onchip = (eff_addr < {4'h0, size_bytes});
  end

  // Status next value, hardware flags applied last
  always @*
  begin
    status_d = status_q;
    if (wr_status)
      status_d = sfr_wdata;
    if (carry_upd)
      status_d[`CSAC_SW_FULL_CARRY] = carry_in;
    if (half_upd)
      status_d[`CSAC_SW_HALF_CARRY] = half_in;
    if (range_upd)
      status_d[`CSAC_SW_RANGE] = range_in;
    status_d[`CSAC_SW_PARITY] = ^main_operand_register;
  end

  // Status word
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      status_q <= `CSAC_STATUS_RESET;
    else
      status_q <= status_d;
  end

  // Auxiliary control, reserved bit held at zero
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      aux_q <= `CSAC_AUX_RESET;
    else if (wr_aux)
      aux_q <= {1'b0, sfr_wdata[6:0]};
  end

  // Pointer select and boot control, writable bits only
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      ptrboot_q <= `CSAC_PTRBOOT_RESET;
    else if (wr_ptrboot)
      ptrboot_q <= sfr_wdata & `CSAC_PB_WMASK;
  end

  // Data pointer 0, written while pointer select is clear
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      ptr0_q <= 16'h0000;
    else if (!pointer_select)
    begin
      if (wr_ptr_high)
        ptr0_q[15:8] <= sfr_wdata;
      if (wr_ptr_low)
        ptr0_q[7:0] <= sfr_wdata;
    end
  end

  // Data pointer 1, written while pointer select is set
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      ptr1_q <= 16'h0000;
    else if (pointer_select)
    begin
      if (wr_ptr_high)
        ptr1_q[15:8] <= sfr_wdata;
      if (wr_ptr_low)
        ptr1_q[7:0] <= sfr_wdata;
    end
  end

  // Register read mux
  always @*
  begin
    case (sfr_addr)
      `CSAC_ADDR_STATUS:   sfr_rdata = status_q;
      `CSAC_ADDR_AUX:      sfr_rdata = {1'b0, aux_q[6:0]};
      `CSAC_ADDR_PTRBOOT:  sfr_rdata = ptrboot_q;
      `CSAC_ADDR_PTR_HIGH: sfr_rdata = ptr_cur[15:8];
      `CSAC_ADDR_PTR_LOW:  sfr_rdata = ptr_cur[7:0];
      default:             sfr_rdata = 8'h00;
    endcase
  end

  // Move routing pulses
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      move_onchip_q  <= 1'b0;
      move_offchip_q <= 1'b0;
    end
    else
    begin
      move_onchip_q  <= move_accept && go_onchip;
      move_offchip_q <= move_accept && !go_onchip;
    end
  end

  // Move address and upper port value
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      move_addr_q          <= 16'h0000;
      upper_address_port_q <= 8'h00;
    end
    else if (move_accept)
    begin
      move_addr_q <= eff_addr;
      if (move_ptr && !aux_q[`CSAC_AX_PHSUP])
        upper_address_port_q <= ptr_cur[15:8];
      else
        upper_address_port_q <= upper_address_port_sfr;
    end
  end

  // Strobe and latch pulse timing
  csac_bus_timer u_timer (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .stretch    (aux_q[`CSAC_AX_STRETCH]),
    .latch_gate (aux_q[`CSAC_AX_LATCH_GATE]),
    .move_start (move_start_offchip),
    .strobe_q   (rw_strobe),
    .latch_q    (addr_latch_strobe),
    .busy       (move_busy)
  );
endmodule // csac_core_regs

//--- csac_xmem.sv
// Off-chip data memory model timing the read or write strobe
`timescale 1ns/1ps
module csac_xmem (
  // Clock and strobe
  input  wire       clk_sys,
  input  wire       rw_strobe,
  // Last strobe width
  output reg  [4:0] width_q
);
  reg [4:0] cnt_q = 5'h0;
  initial width_q = 5'h0;
  always @(posedge clk_sys)
  begin
    if (rw_strobe)
      cnt_q <= cnt_q + 5'h1;
    else if (cnt_q != 5'h0)
    begin
      width_q <= cnt_q;
      cnt_q   <= 5'h0;
    end
  end
endmodule // csac_xmem

//--- csac_core_regs_assertions.sv
// Checker for the core status and auxiliary control registers
`timescale 1ns/1ps
module csac_chk (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst_n,
  // Register access
  input wire logic        sfr_wr,
  input wire logic [7:0]  sfr_addr,
  input wire logic [7:0]  sfr_wdata,
  input wire logic [7:0]  sfr_rdata,
  // Flag inputs
  input wire logic        carry_upd,
  input wire logic        carry_in,
  input wire logic [7:0]  main_operand_register,
  // Watched outputs
  input wire logic        move_offchip_q,
  input wire logic        rw_strobe,
  input wire logic        addr_latch_strobe,
  input wire logic        pointer_select,
  input wire logic        wide_transfer_enable,
  input wire logic [1:0]  working_bank_select,
  input wire logic [11:0] onchip_memory_bytes
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire wa = sfr_wr && sfr_addr == 8'h8E;
  aux_wide_a: assert property (wa |=> wide_transfer_enable == $past(sfr_wdata[6])) else $error("wide");
  mem_size_a: assert property (wa |=> onchip_memory_bytes == 12'h100 << $past(sfr_wdata[3:2]))
    else $error("size");
  bank_sel_a: assert property (sfr_wr && sfr_addr == 8'hD0 |=> working_bank_select == $past(sfr_wdata[4:3]))
    else $error("bank");
  ptr_sel_a: assert property (sfr_wr && sfr_addr == 8'hA2 |=> pointer_select == $past(sfr_wdata[0]))
    else $error("ptr");
  carry_load_a: assert property (carry_upd ##1 sfr_addr == 8'hD0 |-> sfr_rdata[7] == $past(carry_in))
    else $error("cy");
  parity_a: assert property ($past(rst_n) && sfr_addr == 8'hD0 |-> sfr_rdata[0] == ^$past(main_operand_register))
    else $error("parity");
  strobe_min_a: assert property (move_offchip_q |=> rw_strobe [*3]) else $error("strobe");
  latch_gap_a: assert property (addr_latch_strobe |=> !addr_latch_strobe [*2]) else $error("latch");
  cover property (move_offchip_q);
  cover property (wa);
  cover property (carry_upd);
endmodule // csac_chk
bind csac_core_regs csac_chk chk (.*);

//--- csac_core_regs_tb.sv
// Testbench for the core status and auxiliary control registers
`timescale 1ns/1ps
module csac_core_regs_tb;
  reg         clk_sys = 0, rst_n = 0, sfr_wr = 0, move_req = 0, move_ptr = 0;
  reg         carry_upd = 0, carry_in = 0, half_upd = 0, half_in = 0, range_upd = 0, range_in = 0;
  reg  [7:0]  sfr_addr = 0, sfr_wdata = 0, main_operand_register = 0, upper_address_port_sfr = 0, d;
  wire [7:0]  sfr_rdata, upper_address_port_q;
  wire [15:0] move_addr_q;
  wire [11:0] onchip_memory_bytes;
  wire [4:0]  width_q;
  wire [1:0]  working_bank_select;
  wire        wide_transfer_enable, pointer_select, move_onchip_q, move_offchip_q;
  wire        rw_strobe, addr_latch_strobe, move_busy;
  integer     mismatches = 0, n_tests = 0, i, n;
  always #5 clk_sys = ~clk_sys;
  csac_core_regs dut (.*);
  csac_xmem xmem (.clk_sys(clk_sys), .rw_strobe(rw_strobe), .width_q(width_q));
  task chk(input [39:0] nm, input [15:0] e, input [15:0] g);
  begin
    n_tests = n_tests + 1;
    if (e !== g)
    begin
      mismatches = mismatches + 1;
      $display("CHECK FAILED %0s exp %h got %h", nm, e, g);
    end
  end
  endtask
  function [11:0] exp_size(input [1:0] s);
  begin
    case (s)
      2'b00:   exp_size = 12'h100;
      2'b01:   exp_size = 12'h200;
      2'b10:   exp_size = 12'h400;
      default: exp_size = 12'h800;
    endcase
  end
  endfunction
  task wr(input [7:0] a, input [7:0] v);
  begin
    sfr_addr = a;
    sfr_wdata = v;
    sfr_wr = 1;
    @(negedge clk_sys) sfr_wr = 0;
    @(negedge clk_sys);
  end
  endtask
  task rdc(input [7:0] a, input [7:0] e);
  begin
    sfr_addr = a;
    #1 chk("rdata", e, sfr_rdata);
  end
  endtask
  task mv(input [7:0] aux, input p, input [4:0] w);
  begin
    wr(8'h8E, aux);
    move_ptr = p;
    upper_address_port_sfr = aux[1] ? $urandom : 8'h0;
    main_operand_register = $urandom;
    move_req = 1;
    @(negedge clk_sys) move_req = 0;
    chk("busy", aux[1], move_busy);
    chk("addr", p ? 16'h5A3C : {upper_address_port_sfr, main_operand_register}, move_addr_q);
    chk("upper", p && !aux[4] ? 8'h5A : upper_address_port_sfr, upper_address_port_q);
    chk("route", {aux[1], !aux[1]}, {move_offchip_q, move_onchip_q});
    for (n = 0; n < 40 && move_busy; n = n + 1) @(negedge clk_sys);
    @(negedge clk_sys) chk("width", w, width_q);
  end
  endtask
  task end_of_test;
  begin
    if (mismatches == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  end
  endtask
  initial
  begin
    #100000 mismatches = mismatches + 1;
    end_of_test;
  end
  initial
  begin
    n = $urandom(62);
    repeat (10) @(negedge clk_sys);
    rst_n = 1;
    rdc(8'hD0, 8'h00);
    rdc(8'h8E, 8'h0D);
    chk("size", exp_size(2'b11), onchip_memory_bytes);
    for (i = 0; i < 20; i = i + 1)
    begin
      d = $urandom & 8'h7F;
      wr(8'h8E, d);
      rdc(8'h8E, d);
      chk("size", exp_size(d[3:2]), onchip_memory_bytes);
      d = $urandom;
      main_operand_register = $urandom;
      wr(8'hD0, d);
      rdc(8'hD0, {d[7:1], ^main_operand_register});
      chk("bank", d[4:3], working_bank_select);
    end
    {carry_upd, half_upd, range_upd} = 3'h7;
    main_operand_register = 8'h0;
    wr(8'hD0, 8'hFF);
    rdc(8'hD0, 8'h3A);
    {carry_in, half_in, range_in} = 3'h7;
    @(negedge clk_sys) {carry_upd, half_upd, range_upd} = 3'h0;
    rdc(8'hD0, 8'hFE);
    wr(8'h83, 8'h5A);
    wr(8'h84, 8'h3C);
    wr(8'hA2, 8'h01);
    wr(8'h83, 8'hC3);
    rdc(8'h83, 8'hC3);
    wr(8'hA2, 8'h00);
    rdc(8'h83, 8'h5A);
    mv(8'h02, 0, 3);
    mv(8'h22, 0, 15);
    mv(8'h12, 1, 3);
    mv(8'h42, 1, 3);
    mv(8'h00, 0, 3);
    for (i = 0; i < 2; i = i + 1)
    begin
      wr(8'h8E, {7'h0, i[0]});
      d = 8'h0;
      repeat (30) @(negedge clk_sys) d = d + addr_latch_strobe;
      chk("latch", i ? 8'h0 : 8'hA, d);
    end
    end_of_test;
  end
endmodule // csac_core_regs_tb
